// ---- dio_cmd_regs.vh ----
// register map, field positions, characters and timing of the dio command block
`ifndef DIO_CMD_REGS_VH
`define DIO_CMD_REGS_VH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define RX_DATA_OFS      12'h000
`define TX_DATA_OFS      12'h004
`define STATUS_OFS       12'h008
`define NEXT_ADDR_OFS    12'h00c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RX_EOF_BIT       8
`define TX_VALID_BIT     8
`define ST_MODBUS_BIT    0
`define ST_WD_EN_BIT     1
`define ST_TIMEOUT_BIT   2
`define ST_LED_BIT       3
`define ST_ADDR_LSB      8
`define ST_TXLEFT_LSB    16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NEXT_ADDR_RST    8'h01
`define WD_LIMIT_RST     8'h01

// ----------------------------------------------------------------
// frame characters and codes
// ----------------------------------------------------------------
`define CH_TILDE         8'h7e
`define CH_AT            8'h40
`define CH_STAR          8'h2a
`define CH_BANG          8'h21
`define CH_QUEST         8'h3f
`define CH_GT            8'h3e
`define CH_CR            8'h0d
`define CH_0             8'h30
`define CH_1             8'h31
`define CH_2             8'h32
`define CH_3             8'h33
`define CH_4             8'h34
`define CH_5             8'h35
`define CH_P             8'h50
`define CH_S             8'h53
`define MB_READ_COILS    8'h01
`define MB_READ_INPUTS   8'h02
`define MB_EXC_FLAG      8'h80
`define MB_EXC_FUNC      8'h01
`define MB_EXC_ADDR      8'h02
`define MB_EXC_VALUE     8'h03
`define MB_QTY_MAX       16'h0010

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    25
`define WD_TICK_NS       100000000
`define WD_TICK_CYCLES   (`WD_TICK_NS / `CLK_PERIOD_NS)
`define FLASH_TICKS      8'h05

`endif

// ---- wd_timer.v ----
// host watchdog timer counting tenths of a second
`timescale 1ns/1ps
`include "dio_cmd_regs.vh"

module wd_timer
#(
	parameter TICK_CYCLES = `WD_TICK_CYCLES
)
(
	input  wire       pclk,
	input  wire       presetn,
	input  wire       enable,
	input  wire       restart,
	input  wire [7:0] limit,
	output reg        tick,
	output reg        expire
);

	reg [31:0] cyc;
	reg [7:0]  tenths;

	// ----------------------------------------------------------------
	// tenth-second prescaler
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cyc  <= 32'h0;
			tick <= 1'b0;
		end
		else if (cyc == TICK_CYCLES - 1)
		begin
			cyc  <= 32'h0;
			tick <= 1'b1;
		end
		else
		begin
			cyc  <= cyc + 32'h1;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interval counter, each count one tenth
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tenths <= 8'h0;
			expire <= 1'b0;
		end
		else
		begin
			expire <= 1'b0;
			if (!enable || restart)
				tenths <= 8'h0;
			else if (tick)
			begin
				if (tenths + 8'h1 >= limit)
				begin
					tenths <= 8'h0;
					expire <= 1'b1;
				end
				else
					tenths <= tenths + 8'h1;
			end
		end
	end

endmodule // wd_timer

// ---- dio_module_command_watchdog.v ----
// ascii and modbus command interpreter with host watchdog, apb access
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "dio_cmd_regs.vh"

// What this block does
// - set-watchdog flag 1 enables, 0 disables the host watchdog
// - timeout is two hex chars 01..FF, each count one tenth second
// - missed host-alive while enabled sets timeout status and flashes the led
// - host-alive broadcast restarts every watchdog and gets no reply
// - after timeout the watchdog read shows disabled but keeps the interval
// - clear-status drops timeout and flashing, acks; status then reads clear
// - read-preset returns power-on value for P, safe value for S
// - preset data is two hex value chars followed by two zeros
// - store-preset copies present outputs into power-on or safe value, acks
// - during timeout outputs take safe value; output-set answered with ignore mark
// - strap in normal position at power-on selects modbus rtu mode
// - strap grounded at power-on selects ascii initialization mode
// - new address only takes effect after the next power-on reset
// - sixteen-input coils: readback 20-2F, latch high 40-4F, latch low 60-6F
// - eight-output coils: readback 00-07, latch high 48-4F, latch low 68-6F
// - eight-input coils: readback 20-27, latch high 40-47, latch low 60-67
// - eight-output coils: safe values 80-87, power-on values A0-A7
// - read request: address, start, quantity 1..16; reply one bit per channel
// - rejected read replies function plus 80 and one exception byte
// - function 02 returns inputs; start 0-F or 0-7 by variant
module dio_module_command_watchdog
#(
	parameter VARIANT_8IO = 1'b1,
	parameter TICK_CYCLES = `WD_TICK_CYCLES
)
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        init_strap_n,
	input  wire [7:0]  stored_addr,
	input  wire [15:0] din,
	output reg  [7:0]  dout,
	output reg         led,
	output reg  [7:0]  next_addr
);

	localparam [4:0] DI_N = VARIANT_8IO ? 5'd8 : 5'd16;

	reg  [1:0]  strap_sync;
	reg  [15:0] addr_sync0;
	reg  [15:0] addr_sync1;
	reg  [15:0] din_sync0;
	reg  [15:0] din_sync1;
	reg  [1:0]  boot_cnt;
	reg         booted;
	reg         modbus_mode;
	reg  [7:0]  own_addr;
	reg  [7:0]  rx_buf [0:7];
	reg  [3:0]  rx_len;
	reg         frame_done;
	reg  [7:0]  tx_buf [0:7];
	reg  [3:0]  tx_len;
	reg  [3:0]  tx_rd;
	reg         wd_en;
	reg  [7:0]  wd_limit;
	reg         wd_timeout;
	reg  [7:0]  safe_val;
	reg  [7:0]  pwron_val;
	reg  [15:0] di_lh;
	reg  [15:0] di_ll;
	reg  [7:0]  do_lh;
	reg  [7:0]  do_ll;
	reg  [7:0]  flash_cnt;
	reg         blink;
	wire        wd_tick;
	wire        wd_expire;
	wire [15:0] di = VARIANT_8IO ? {8'h0, din_sync1[7:0]} : din_sync1;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function [4:0] hex_val;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39)
				hex_val = {1'b1, c[3:0]};
			else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
				hex_val = {1'b1, c[3:0] + 4'h9};
			else
				hex_val = 5'h00;
		end
	endfunction

	function [7:0] hex_chr;
		input [3:0] n;
		begin
			hex_chr = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
		end
	endfunction

	// {valid, bit} of one coil or input address
	function [1:0] coil;
		input [7:0]  fc;
		input [15:0] a;
		begin
			coil = 2'b00;
			if (fc == `MB_READ_INPUTS)
			begin
				if (a < {11'h0, DI_N})
					coil = {1'b1, di[a[3:0]]};
			end
			else if (a[15:8] != 8'h00)
				coil = 2'b00;
			else if (!VARIANT_8IO)
			begin
				case (a[7:4])
					4'h2: coil = {1'b1, di[a[3:0]]};
					4'h4: coil = {1'b1, di_lh[a[3:0]]};
					4'h6: coil = {1'b1, di_ll[a[3:0]]};
					default: coil = 2'b00;
				endcase
			end
			else
			begin
				case (a[7:3])
					5'h00: coil = {1'b1, dout[a[2:0]]};
					5'h09: coil = {1'b1, do_lh[a[2:0]]};
					5'h0d: coil = {1'b1, do_ll[a[2:0]]};
					5'h04: coil = {1'b1, di[a[2:0]]};
					5'h08: coil = {1'b1, di_lh[a[2:0]]};
					5'h0c: coil = {1'b1, di_ll[a[2:0]]};
					5'h10: coil = {1'b1, safe_val[a[2:0]]};
					5'h14: coil = {1'b1, pwron_val[a[2:0]]};
					default: coil = 2'b00;
				endcase
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers and power-on capture
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_sync  <= 2'b11;
			addr_sync0  <= 16'h0;
			addr_sync1  <= 16'h0;
			din_sync0   <= 16'h0;
			din_sync1   <= 16'h0;
			boot_cnt    <= 2'h0;
			booted      <= 1'b0;
			modbus_mode <= 1'b1;
			own_addr    <= 8'h0;
		end
		else
		begin
			strap_sync <= {strap_sync[0], init_strap_n};
			addr_sync0 <= {8'h0, stored_addr};
			addr_sync1 <= addr_sync0;
			din_sync0  <= din;
			din_sync1  <= din_sync0;
			if (!booted)
			begin
				boot_cnt <= boot_cnt + 2'h1;
				if (boot_cnt == 2'h3)
				begin
					booted      <= 1'b1;
					modbus_mode <= strap_sync[1];
					own_addr    <= addr_sync1[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// frame decode and response build
	// ----------------------------------------------------------------
	reg  [63:0] resp;
	reg  [3:0]  resp_len;
	reg         act_kick;
	reg         act_wd;
	reg         act_clr;
	reg         act_sp;
	reg         act_ss;
	reg         act_do;
	reg  [7:0]  ah;
	reg  [7:0]  al;
	reg  [4:0]  h0;
	reg  [4:0]  h1;
	reg  [4:0]  h2;
	reg  [4:0]  h3;
	reg  [15:0] mb_start;
	reg  [15:0] mb_qty;
	reg  [15:0] mb_bits;
	reg         mb_ok;
	reg  [1:0]  cb;
	reg  [7:0]  pv;
	reg  [4:0]  k;

	always @*
	begin
		resp = 64'h0; resp_len = 4'h0;
		act_kick = 1'b0; act_wd = 1'b0; act_clr = 1'b0;
		act_sp = 1'b0; act_ss = 1'b0; act_do = 1'b0;
		ah = hex_chr(own_addr[7:4]); al = hex_chr(own_addr[3:0]);
		h0 = hex_val(rx_buf[1]); h1 = hex_val(rx_buf[2]);
		h2 = hex_val(rx_buf[4]); h3 = hex_val(rx_buf[5]);
		mb_start = {rx_buf[2], rx_buf[3]}; mb_qty = {rx_buf[4], rx_buf[5]};
		mb_bits = 16'h0; mb_ok = 1'b1; cb = 2'b00;
		pv = (rx_buf[4] == `CH_P) ? pwron_val : safe_val;
		for (k = 5'd0; k < 5'd16; k = k + 5'd1)
		begin
			cb = coil(rx_buf[1], mb_start + {11'h0, k});
			if ({11'h0, k} < mb_qty)
			begin
				mb_ok = mb_ok & cb[1];
				mb_bits[k[3:0]] = cb[0];
			end
		end
		if (modbus_mode)
		begin
			if (rx_len == 4'h6 && rx_buf[0] == own_addr)
			begin
				resp[7:0] = own_addr;
				resp[15:8] = rx_buf[1] | `MB_EXC_FLAG;
				resp_len = 4'h3;
				if (rx_buf[1] != `MB_READ_COILS && rx_buf[1] != `MB_READ_INPUTS)
					resp[23:16] = `MB_EXC_FUNC;
				else if (mb_qty == 16'h0 || mb_qty > `MB_QTY_MAX)
					resp[23:16] = `MB_EXC_VALUE;
				else if (!mb_ok)
					resp[23:16] = `MB_EXC_ADDR;
				else
				begin
					resp[15:8] = rx_buf[1];
					resp[23:16] = (mb_qty > 16'h8) ? 8'h2 : 8'h1;
					resp[39:24] = {mb_bits[15:8], mb_bits[7:0]};
					resp_len = (mb_qty > 16'h8) ? 4'h5 : 4'h4;
				end
			end
		end
		else if (rx_len == 4'h3 && rx_buf[0] == `CH_TILDE &&
			rx_buf[1] == `CH_STAR && rx_buf[2] == `CH_STAR)
			act_kick = 1'b1;
		else if (rx_len >= 4'h3 && h0[4] && h1[4] && {h0[3:0], h1[3:0]} == own_addr &&
			(rx_buf[0] == `CH_TILDE || rx_buf[0] == `CH_AT))
		begin
			resp[23:0] = {al, ah, `CH_QUEST};
			resp[31:24] = `CH_CR;
			resp_len = 4'h4;
			if (rx_buf[0] == `CH_AT)
			begin
				// output data sits right after the two address characters
				h2 = hex_val(rx_buf[3]);
				h3 = hex_val(rx_buf[4]);
				if (VARIANT_8IO && rx_len == 4'h5 && h2[4] && h3[4])
				begin
					resp[15:0] = wd_timeout ? {`CH_CR, `CH_BANG} : {`CH_CR, `CH_GT};
					resp_len = 4'h2;
					act_do = ~wd_timeout;
				end
			end
			else if (rx_len == 4'h4 && rx_buf[3] == `CH_0)
			begin
				resp[47:0] = {`CH_CR, hex_chr({1'b0, wd_timeout, 2'b00}),
					hex_chr({wd_en, 3'b000}), al, ah, `CH_BANG};
				resp_len = 4'h6;
			end
			else if (rx_len == 4'h4 && rx_buf[3] == `CH_1)
			begin
				resp[31:0] = {`CH_CR, al, ah, `CH_BANG};
				act_clr = 1'b1;
			end
			else if (rx_len == 4'h4 && rx_buf[3] == `CH_2)
			begin
				resp[55:0] = {`CH_CR, hex_chr(wd_limit[3:0]), hex_chr(wd_limit[7:4]),
					wd_en ? `CH_1 : `CH_0, al, ah, `CH_BANG};
				resp_len = 4'h7;
			end
			else if (rx_len == 4'h7 && rx_buf[3] == `CH_3 && h2[4] && h3[4] &&
				(rx_buf[4] == `CH_0 || rx_buf[4] == `CH_1))
			begin
				h2 = hex_val(rx_buf[5]);
				h3 = hex_val(rx_buf[6]);
				if (h2[4] && h3[4] && {h2[3:0], h3[3:0]} != 8'h0)
				begin
					resp[31:0] = {`CH_CR, al, ah, `CH_BANG};
					act_wd = 1'b1;
				end
			end
			else if (rx_len == 4'h5 && (rx_buf[4] == `CH_P || rx_buf[4] == `CH_S))
			begin
				if (rx_buf[3] == `CH_4)
				begin
					resp[63:0] = {`CH_CR, `CH_0, `CH_0, hex_chr(pv[3:0]),
						hex_chr(pv[7:4]), al, ah, `CH_BANG};
					resp_len = 4'h8;
				end
				else if (rx_buf[3] == `CH_5)
				begin
					resp[31:0] = {`CH_CR, al, ah, `CH_BANG};
					act_sp = (rx_buf[4] == `CH_P);
					act_ss = (rx_buf[4] == `CH_S);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// apb slave with no wait states
	// ----------------------------------------------------------------
	wire apb_setup = psel && !penable;
	wire apb_done  = psel && penable && pready;
	wire wr_rx     = apb_done && pwrite && paddr == `RX_DATA_OFS;
	wire rd_tx     = apb_done && !pwrite && paddr == `TX_DATA_OFS;
	wire rx_end    = modbus_mode ? pwdata[`RX_EOF_BIT] : (pwdata[7:0] == `CH_CR);
	integer i;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata    <= 32'h0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			next_addr <= `NEXT_ADDR_RST;
		end
		else if (apb_setup)
		begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (paddr == `TX_DATA_OFS)
				prdata <= (tx_rd < tx_len) ? {23'h0, 1'b1, tx_buf[tx_rd[2:0]]} : 32'h0;
			else if (paddr == `STATUS_OFS)
				prdata <= {12'h0, tx_len - tx_rd, own_addr, 4'h0, led, wd_timeout,
					wd_en, modbus_mode};
			else if (paddr == `NEXT_ADDR_OFS)
				prdata <= {24'h0, next_addr};
			else if (paddr != `RX_DATA_OFS)
				pslverr <= 1'b1;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (apb_done && pwrite && paddr == `NEXT_ADDR_OFS)
				next_addr <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// receive and transmit buffers
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_len     <= 4'h0;
			frame_done <= 1'b0;
			tx_len     <= 4'h0;
			tx_rd      <= 4'h0;
			for (i = 0; i < 8; i = i + 1)
			begin
				rx_buf[i] <= 8'h0;
				tx_buf[i] <= 8'h0;
			end
		end
		else
		begin
			frame_done <= wr_rx && rx_end && booted;
			if (frame_done)
			begin
				rx_len <= 4'h0;
				tx_len <= resp_len;
				tx_rd  <= 4'h0;
				for (i = 0; i < 8; i = i + 1)
					tx_buf[i] <= resp[8*i +: 8];
			end
			else
			begin
				if (wr_rx && !(rx_end && !modbus_mode))
				begin
					if (rx_len < 4'h8)
						rx_buf[rx_len[2:0]] <= pwdata[7:0];
					rx_len <= (rx_len < 4'h8) ? rx_len + 4'h1 : 4'hf;
				end
				if (rd_tx && tx_rd < tx_len)
					tx_rd <= tx_rd + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog, outputs, presets, latches, led
	// ----------------------------------------------------------------
	wd_timer #(.TICK_CYCLES(TICK_CYCLES)) u_wd
	(
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (wd_en),
		.restart (frame_done && (act_kick || act_wd || act_clr)),
		.limit   (wd_limit),
		.tick    (wd_tick),
		.expire  (wd_expire)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wd_en      <= 1'b0;
			wd_limit   <= `WD_LIMIT_RST;
			wd_timeout <= 1'b0;
			safe_val   <= 8'h0;
			pwron_val  <= 8'h0;
			dout       <= 8'h0;
			di_lh      <= 16'h0;
			di_ll      <= 16'h0;
			do_lh      <= 8'h0;
			do_ll      <= 8'h0;
			flash_cnt  <= 8'h0;
			blink      <= 1'b0;
			led        <= 1'b0;
		end
		else
		begin
			di_lh <= di_lh | di;
			di_ll <= di_ll | (~di & (VARIANT_8IO ? 16'h00ff : 16'hffff));
			do_lh <= do_lh | dout;
			do_ll <= do_ll | ~dout;
			if (frame_done && act_wd)
			begin
				wd_en    <= (rx_buf[4] == `CH_1);
				wd_limit <= {h2[3:0], h3[3:0]};
			end
			if (wd_expire && wd_en)
			begin
				wd_timeout <= 1'b1;
				wd_en      <= 1'b0;
			end
			else if (frame_done && act_clr)
				wd_timeout <= 1'b0;
			if (frame_done && act_sp)
				pwron_val <= dout;
			if (frame_done && act_ss)
				safe_val <= dout;
			if (wd_timeout)
				dout <= safe_val;
			else if (frame_done && act_do)
				dout <= {h2[3:0], h3[3:0]};
			if (!wd_timeout)
			begin
				flash_cnt <= 8'h0;
				blink     <= 1'b0;
			end
			else if (wd_tick)
			begin
				flash_cnt <= (flash_cnt + 8'h1 >= `FLASH_TICKS) ? 8'h0 : flash_cnt + 8'h1;
				if (flash_cnt + 8'h1 >= `FLASH_TICKS)
					blink <= ~blink;
			end
			led <= wd_timeout & blink;
		end
	end

endmodule // dio_module_command_watchdog

// ---- dio_field_side.sv ----
// pin-side model: strap switch, stored address and input channels
`timescale 1ns/1ps

module dio_field_side
(
	input  wire logic        strap_ground,
	output logic             init_strap_n,
	output logic [7:0]       stored_addr,
	output logic [15:0]      din,
	input  wire logic [7:0]  dout
);
	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	assign init_strap_n = !strap_ground;
	assign stored_addr  = 8'h01;
	// fixed active pattern on the eight input channels
	assign din          = 16'h00a5;
endmodule // dio_field_side

// ---- dio_cmd_monitor.sv ----
// port checker for the dio command block
`timescale 1ns/1ps
`include "dio_cmd_regs.vh"

module dio_cmd_monitor
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [31:0] prdata,
	input  wire        pready,
	input  wire        pslverr,
	input  wire        init_strap_n,
	input  wire [7:0]  stored_addr,
	input  wire [15:0] din,
	input  wire [7:0]  dout,
	input  wire        led,
	input  wire [7:0]  next_addr
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire done = psel && penable && pready;
	wire mapped = paddr == `RX_DATA_OFS || paddr == `TX_DATA_OFS
		|| paddr == `STATUS_OFS || paddr == `NEXT_ADDR_OFS;
	wire st_rd = done && !pwrite && paddr == `STATUS_OFS;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	AST_ERR_UNMAPPED: assert property (done && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_ERR_MAPPED: assert property (pslverr |-> pready && !mapped)
		else $error("pslverr on mapped access");
	AST_NEXT_ADDR_WRITE: assert property (done && pwrite && paddr == `NEXT_ADDR_OFS
		|=> next_addr == $past(pwdata[7:0])) else $error("next address not stored");
	AST_NEXT_ADDR_HOLD: assert property ($changed(next_addr)
		|-> $past(done && pwrite && paddr == `NEXT_ADDR_OFS)) else $error("next address moved");
	AST_ADDR_FIELD: assert property (st_rd |-> prdata[15:8] == stored_addr)
		else $error("active address differs from stored address");
	AST_MODE_STRAP: assert property (st_rd |-> prdata[0] == init_strap_n)
		else $error("mode differs from strap");
	AST_LED_FLASH: assert property ($rose(led) |=> $stable(led) [*8])
		else $error("led flash period too short");
endmodule // dio_cmd_monitor

bind dio_module_command_watchdog dio_cmd_monitor i_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .init_strap_n(init_strap_n),
	.stored_addr(stored_addr), .din(din), .dout(dout), .led(led), .next_addr(next_addr));

// ---- dio_module_command_watchdog_bench.sv ----
// apb bench for ascii, watchdog, preset and modbus behaviour
`timescale 1ns/1ps
`include "dio_cmd_regs.vh"

module dio_module_command_watchdog_bench;
	logic        pclk, presetn, psel, penable, pwrite, strap_ground;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, init_strap_n, led, e;
	logic        seen_hi, seen_lo;
	logic [7:0]  stored_addr, dout, next_addr;
	logic [15:0] din;
	integer      miscompares, comparisons;

	dio_module_command_watchdog #(.VARIANT_8IO(1'b1), .TICK_CYCLES(10)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.init_strap_n(init_strap_n), .stored_addr(stored_addr), .din(din), .dout(dout),
		.led(led), .next_addr(next_addr));
	dio_field_side i_field (.strap_ground(strap_ground), .init_strap_n(init_strap_n),
		.stored_addr(stored_addr), .din(din), .dout(dout));

	initial
	begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task wrap_up;
	begin
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
	begin
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer n;
	begin
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
		if (n >= 20)
		begin
			miscompares++;
			wrap_up();
		end
	end
	endtask
	task idle(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	task send(input string s);
		integer i;
	begin
		for (i = 0; i < s.len(); i++)
			apb(1, `RX_DATA_OFS, {24'h0, s[i]});
		apb(1, `RX_DATA_OFS, 32'h0d);
		idle(3);
	end
	endtask
	task reply(input string s);
		integer i;
	begin
		for (i = 0; i < s.len(); i++)
		begin
			apb(0, `TX_DATA_OFS, 0);
			check("tx byte", {23'h0, 1'b1, s[i]}, r & 32'h1ff);
		end
		apb(0, `TX_DATA_OFS, 0);
		check("tx cr", 32'h10d, r & 32'h1ff);
		apb(0, `TX_DATA_OFS, 0);
		check("tx empty", 0, {31'h0, r[8]});
	end
	endtask
	task silent;
	begin
		apb(0, `TX_DATA_OFS, 0);
		check("tx silent", 0, {31'h0, r[8]});
	end
	endtask
	task mb(input logic [47:0] f, input logic [31:0] v, input integer n);
		integer i;
	begin
		for (i = 0; i < 6; i++)
			apb(1, `RX_DATA_OFS, {23'h0, i == 5, f[8*(5-i) +: 8]});
		idle(3);
		for (i = 0; i < n; i++)
		begin
			apb(0, `TX_DATA_OFS, 0);
			check("mb byte", {23'h0, 1'b1, v[8*(n-1-i) +: 8]}, r & 32'h1ff);
		end
	end
	endtask
	task status(input logic [31:0] exp);
	begin
		apb(0, `STATUS_OFS, 0);
		check("status", exp, r & 32'h0000ff07);
	end
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		miscompares = 0; comparisons = 0;
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		strap_ground = 1;
		idle(2);
		presetn <= 1;
		idle(6);
		status(32'h0100);
		send("@01AA"); reply(">");
		check("dout", 32'haa, {24'h0, dout});
		send("~015P"); reply("!01");
		send("@0155"); reply(">");
		send("~015S"); reply("!01");
		send("@0100"); reply(">");
		send("~014P"); reply("!01AA00");
		send("~014S"); reply("!015500");
		send("~020"); silent();
		send("~013164"); reply("!01");
		send("~012"); reply("!01164");
		send("~010"); reply("!0180");
		idle(600);
		send("~**"); silent();
		idle(600);
		status(32'h0102);
		idle(1100);
		status(32'h0104);
		seen_hi = 0;
		seen_lo = 0;
		repeat (120)
		begin
			@(posedge pclk);
			seen_hi |= led;
			seen_lo |= !led;
		end
		check("led flash", 32'h3, {30'h0, seen_hi, seen_lo});
		send("~010"); reply("!0104");
		send("~012"); reply("!01064");
		check("safe dout", 32'h55, {24'h0, dout});
		send("@01AA"); reply("!");
		check("held dout", 32'h55, {24'h0, dout});
		send("~011"); reply("!01");
		check("led off", 32'h0, {31'h0, led});
		send("~010"); reply("!0100");
		send("~013100"); reply("?01");
		send("~013001"); reply("!01");
		status(32'h0100);
		apb(1, `NEXT_ADDR_OFS, 32'h05);
		apb(0, `NEXT_ADDR_OFS, 0);
		check("next addr", 32'h05, r & 32'hff);
		check("next addr pin", 32'h05, {24'h0, next_addr});
		status(32'h0100);
		apb(0, 12'h010, 0);
		check("unmapped", 32'h1, {31'h0, e});
		@(posedge pclk);
		presetn <= 0; strap_ground <= 0;
		idle(2);
		presetn <= 1;
		idle(6);
		status(32'h0101);
		mb(48'h0101_0020_0008, 32'h010101a5, 4);
		mb(48'h0102_0000_0008, 32'h010201a5, 4);
		mb(48'h0101_0000_0000, 32'h00018103, 3);
		mb(48'h0102_0008_0001, 32'h00018202, 3);
		mb(48'h0107_0000_0001, 32'h00018701, 3);
		mb(48'h0201_0020_0008, 32'h0, 0); silent();
		wrap_up();
	end
endmodule // dio_module_command_watchdog_bench
